// *** rtl/eag_map.vh ***
`ifndef EAG_MAP_VH
`define EAG_MAP_VH
// ==================================================
// Register word indices (address bits 7:2)
`define EAG_OFS_CTRL      6'h00
`define EAG_OFS_CMD       6'h01
`define EAG_OFS_TIME      6'h02
`define EAG_OFS_ERRTGT    6'h03
`define EAG_OFS_BITS_LO   6'h04
`define EAG_OFS_BITS_HI   6'h05
`define EAG_OFS_LOC_START 6'h06
`define EAG_OFS_LOC_LEN   6'h07
`define EAG_OFS_STATUS    6'h08
`define EAG_OFS_ERRCNT    6'h09
`define EAG_OFS_BITCNT_LO 6'h0a
`define EAG_OFS_BITCNT_HI 6'h0b
`define EAG_OFS_ELAPSED   6'h0c
`define EAG_OFS_IRQ_STAT  6'h0d
`define EAG_OFS_IRQ_MASK  6'h0e
`define EAG_OFS_LIVE_ERR  6'h0f
`define EAG_OFS_LIVE_BITS 6'h10
// ==================================================
// Control field positions
`define EAG_CTRL_MODE_LSB 0
`define EAG_CTRL_PER_LSB  2
`define EAG_CTRL_LOC_LSB  4
`define EAG_CTRL_CMP_LSB  6
// ==================================================
// Field encodings
`define EAG_MODE_MANUAL   2'h0
`define EAG_MODE_SINGLE   2'h1
`define EAG_MODE_REPEAT   2'h2
`define EAG_PER_TIME      2'h0
`define EAG_PER_ERRORS    2'h1
`define EAG_PER_BITS      2'h2
`define EAG_LOC_ALL       2'h0
`define EAG_LOC_BLOCK     2'h1
`define EAG_LOC_SINGLE    2'h2
`define EAG_CMP_BIT       2'h0
// ==================================================
// Limits and reset values
`define EAG_TIME_MIN      24'h000001
`define EAG_TIME_MAX      24'h83d5ff
`define EAG_ERR_T10       11'h00a
`define EAG_ERR_T100      11'h064
`define EAG_ERR_T1000     11'h3e8
`define EAG_BITS_MIN      50'h00000_00989680
`define EAG_BITS_MAX      50'h38d7e_a4c68000
`define EAG_RST_TIME      24'h00003c
`define EAG_RST_BITS      50'h00000_3b9aca00
`define EAG_RST_LOC_LEN   32'h00000001
// ==================================================
// Timing
`define EAG_CLK_HZ        50000000
`define EAG_SEC_S         1
`define EAG_SEC_CYCLES    (`EAG_CLK_HZ * `EAG_SEC_S)
// Interrupt bits
`define EAG_IRQ_END       0
`define EAG_IRQ_TGT       1
`define EAG_IRQ_START     2
`endif

// *** rtl/eag_core.v ***
`timescale 1ns/1ps
`include "eag_map.vh"

module eag_core #(
    parameter SEC_CYCLES = `EAG_SEC_CYCLES
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    // Avalon-MM slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Compared data from the pattern checker
    input  wire        rx_valid,
    input  wire        rx_err,
    input  wire [31:0] rx_pos,
    // Status
    output reg         running,
    output wire        irq
);

    // ==================================================
    // Declarations
    reg  [1:0]  cfg_mode;
    reg  [1:0]  cfg_per;
    reg  [1:0]  cfg_loc;
    reg  [1:0]  cfg_cmp;
    reg  [23:0] cfg_time;
    reg  [10:0] cfg_errtgt;
    reg  [49:0] cfg_bits;
    reg  [31:0] cfg_loc_start;
    reg  [31:0] cfg_loc_len;
    reg  [1:0]  act_mode;
    reg  [1:0]  act_per;
    reg  [1:0]  act_loc;
    reg  [23:0] act_time;
    reg  [10:0] act_errtgt;
    reg  [49:0] act_bits;
    reg  [31:0] act_loc_start;
    reg  [31:0] act_loc_len;
    reg  [31:0] err_cnt;
    reg  [49:0] bit_cnt;
    reg  [23:0] elapsed;
    reg  [31:0] sec_cnt;
    reg         tgt_hit;
    reg  [31:0] live_err;
    reg  [31:0] live_bits;
    reg  [2:0]  irq_stat;
    reg  [2:0]  irq_mask;
    reg         rd_ack;
    reg  [31:0] next_readdata;
    wire [5:0]  reg_idx;
    wire        wr_en;
    wire        rd_en;
    wire        cmd_start;
    wire        cmd_stop;
    wire        sec_tick;
    wire        err_match;
    wire        period_end;
    wire        begin_period;
    wire        tgt_now;
    wire [1:0]  wr_mode;
    wire [1:0]  wr_per;
    wire [1:0]  wr_loc;
    wire [1:0]  wr_cmp;

    // ==================================================
    // Position filter: true when pos lies in [start, start + len)
    function in_block;
        input [31:0] pos;
        input [31:0] start;
        input [31:0] len;
        reg   [31:0] off;
        begin
            off      = pos - start;
            in_block = (pos >= start) && (off < len);
        end
    endfunction

    // ==================================================
    // Bus decode; writes never wait, reads wait one cycle
    assign reg_idx         = avs_address[7:2];
    assign wr_en           = avs_write;
    assign rd_en           = avs_read & rd_ack;
    assign avs_waitrequest = avs_read & ~rd_ack;
    assign cmd_start       = wr_en && (reg_idx == `EAG_OFS_CMD) && avs_writedata[0];
    assign cmd_stop        = wr_en && (reg_idx == `EAG_OFS_CMD) && avs_writedata[1];
    assign wr_mode         = avs_writedata[`EAG_CTRL_MODE_LSB +: 2];
    assign wr_per          = avs_writedata[`EAG_CTRL_PER_LSB +: 2];
    assign wr_loc          = avs_writedata[`EAG_CTRL_LOC_LSB +: 2];
    assign wr_cmp          = avs_writedata[`EAG_CTRL_CMP_LSB +: 2];

    // Read wait state, cleared as the read is accepted
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= avs_read & ~rd_ack;
        end
    end

    // ==================================================
    // Pending configuration written by software
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg_mode      <= `EAG_MODE_MANUAL;
            cfg_per       <= `EAG_PER_TIME;
            cfg_loc       <= `EAG_LOC_ALL;
            cfg_cmp       <= `EAG_CMP_BIT;
            cfg_time      <= `EAG_RST_TIME;
            cfg_errtgt    <= `EAG_ERR_T10;
            cfg_bits      <= `EAG_RST_BITS;
            cfg_loc_start <= 32'h00000000;
            cfg_loc_len   <= `EAG_RST_LOC_LEN;
            irq_mask      <= 3'h0;
        end else if (wr_en) begin
            case (reg_idx)
                `EAG_OFS_CTRL: begin
                    if (!running && wr_mode != 2'h3) begin
                        cfg_mode <= wr_mode;
                    end
                    if (!running && wr_per != 2'h3) begin
                        cfg_per <= wr_per;
                    end
                    cfg_cmp <= wr_cmp;
                    if (wr_cmp != `EAG_CMP_BIT && (wr_loc == `EAG_LOC_SINGLE
                        || (wr_loc == 2'h3 && cfg_loc == `EAG_LOC_SINGLE))) begin
                        cfg_loc <= `EAG_LOC_ALL;
                    end else if (wr_loc != 2'h3) begin
                        cfg_loc <= wr_loc;
                    end
                end
                `EAG_OFS_TIME: begin
                    if (!running && avs_writedata[23:0] >= `EAG_TIME_MIN
                        && avs_writedata[23:0] <= `EAG_TIME_MAX
                        && avs_writedata[31:24] == 8'h00) begin
                        cfg_time <= avs_writedata[23:0];
                    end
                end
                `EAG_OFS_ERRTGT: begin
                    if (!running && avs_writedata[31:11] == 21'h0
                        && (avs_writedata[10:0] == `EAG_ERR_T10
                        || avs_writedata[10:0] == `EAG_ERR_T100
                        || avs_writedata[10:0] == `EAG_ERR_T1000)) begin
                        cfg_errtgt <= avs_writedata[10:0];
                    end
                end
                `EAG_OFS_BITS_LO: begin
                    if (!running) begin
                        cfg_bits[31:0] <= avs_writedata;
                    end
                end
                `EAG_OFS_BITS_HI: begin
                    if (!running) begin
                        cfg_bits[49:32] <= avs_writedata[17:0];
                    end
                end
                `EAG_OFS_LOC_START: cfg_loc_start <= avs_writedata;
                `EAG_OFS_LOC_LEN:   cfg_loc_len   <= avs_writedata;
                `EAG_OFS_IRQ_MASK:  irq_mask      <= avs_writedata[2:0];
                default: ;
            endcase
        end
    end

    // ==================================================
    // Period control
    assign sec_tick  = running && (sec_cnt == SEC_CYCLES - 1);
    assign err_match = rx_valid && rx_err && (
        (act_loc == `EAG_LOC_ALL) ||
        (act_loc == `EAG_LOC_BLOCK && in_block(rx_pos, act_loc_start,
                                               act_loc_len)) ||
        (act_loc == `EAG_LOC_SINGLE && rx_pos == act_loc_start));
    assign tgt_now   = running && act_per == `EAG_PER_ERRORS && !tgt_hit
                       && (err_cnt[10:0] >= act_errtgt || err_cnt[31:11] != 21'h0);

    // End conditions apply only outside manual mode
    assign period_end = running && (act_mode != `EAG_MODE_MANUAL) && (
        (act_per == `EAG_PER_TIME   && sec_tick && elapsed + 24'h1 >= act_time) ||
        (act_per == `EAG_PER_ERRORS && sec_tick && (tgt_hit || tgt_now)) ||
        (act_per == `EAG_PER_BITS   && bit_cnt > act_bits));

    // A new period starts on a start command, or straight after a repeat period
    assign begin_period = (!running && cmd_start) ||
                          (period_end && act_mode == `EAG_MODE_REPEAT && !cmd_stop);

    // Run flag and settings applied at period start
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            running       <= 1'b0;
            act_mode      <= `EAG_MODE_MANUAL;
            act_per       <= `EAG_PER_TIME;
            act_loc       <= `EAG_LOC_ALL;
            act_time      <= `EAG_RST_TIME;
            act_errtgt    <= `EAG_ERR_T10;
            act_bits      <= `EAG_RST_BITS;
            act_loc_start <= 32'h00000000;
            act_loc_len   <= `EAG_RST_LOC_LEN;
        end else if (begin_period) begin
            running       <= 1'b1;
            act_mode      <= cfg_mode;
            act_per       <= cfg_per;
            act_loc       <= cfg_loc;
            act_time      <= cfg_time;
            act_errtgt    <= cfg_errtgt;
            act_bits      <= cfg_bits;
            act_loc_start <= cfg_loc_start;
            act_loc_len   <= cfg_loc_len;
        end else if (cmd_stop || period_end) begin
            running <= 1'b0;
        end
    end

    // ==================================================
    // Accumulation counters, cleared at each period start
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            err_cnt <= 32'h00000000;
            bit_cnt <= 50'h0;
            elapsed <= 24'h000000;
            sec_cnt <= 32'h00000000;
            tgt_hit <= 1'b0;
        end else if (begin_period) begin
            err_cnt <= 32'h00000000;
            bit_cnt <= 50'h0;
            elapsed <= 24'h000000;
            sec_cnt <= 32'h00000000;
            tgt_hit <= 1'b0;
        end else if (running) begin
            if (err_match && err_cnt != 32'hffffffff) begin
                err_cnt <= err_cnt + 32'h1;
            end
            if (rx_valid) begin
                bit_cnt <= bit_cnt + 50'h1;
            end
            if (tgt_now) begin
                tgt_hit <= 1'b1;
            end
            if (sec_tick) begin
                sec_cnt <= 32'h00000000;
                elapsed <= elapsed + 24'h1;
            end else begin
                sec_cnt <= sec_cnt + 32'h1;
            end
        end
    end

    // ==================================================
    // Live counters run with any received data
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            live_err  <= 32'h00000000;
            live_bits <= 32'h00000000;
        end else if (rx_valid) begin
            live_bits <= live_bits + 32'h1;
            if (rx_err) begin
                live_err <= live_err + 32'h1;
            end
        end
    end

    // ==================================================
    // Sticky interrupt status; a read clears only the bits it returned, so an
    // event latched during the read wait cycle is kept; a set wins the clear
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat <= 3'h0;
        end else begin
            irq_stat <= ((rd_en && reg_idx == `EAG_OFS_IRQ_STAT) ?
                         (irq_stat & ~avs_readdata[2:0]) : irq_stat)
                        | {begin_period, tgt_now, period_end};
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==================================================
    // Read data mux
    always @* begin
        next_readdata = 32'h00000000;
        case (reg_idx)
            `EAG_OFS_CTRL:      next_readdata = {24'h0, cfg_cmp, cfg_loc, cfg_per, cfg_mode};
            `EAG_OFS_TIME:      next_readdata = {8'h00, cfg_time};
            `EAG_OFS_ERRTGT:    next_readdata = {21'h0, cfg_errtgt};
            `EAG_OFS_BITS_LO:   next_readdata = cfg_bits[31:0];
            `EAG_OFS_BITS_HI:   next_readdata = {14'h0, cfg_bits[49:32]};
            `EAG_OFS_LOC_START: next_readdata = cfg_loc_start;
            `EAG_OFS_LOC_LEN:   next_readdata = cfg_loc_len;
            `EAG_OFS_STATUS:    next_readdata = {24'h0, act_loc, act_per, act_mode,
                                                 tgt_hit, running};
            `EAG_OFS_ERRCNT:    next_readdata = err_cnt;
            `EAG_OFS_BITCNT_LO: next_readdata = bit_cnt[31:0];
            `EAG_OFS_BITCNT_HI: next_readdata = {14'h0, bit_cnt[49:32]};
            `EAG_OFS_ELAPSED:   next_readdata = {8'h00, elapsed};
            `EAG_OFS_IRQ_STAT:  next_readdata = {29'h0, irq_stat};
            `EAG_OFS_IRQ_MASK:  next_readdata = {29'h0, irq_mask};
            `EAG_OFS_LIVE_ERR:  next_readdata = live_err;
            `EAG_OFS_LIVE_BITS: next_readdata = live_bits;
            default:            next_readdata = 32'h00000000;
        endcase
    end

    // Read data register, loaded in the wait cycle
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && !rd_ack) begin
            avs_readdata <= next_readdata;
        end
    end

endmodule

// *** tb/eag_core_assertions.sv ***
`timescale 1ns/1ps
// ========================================
// Port checker for the accumulation gate
module eag_core_assertions #(
    parameter SEC_CYCLES = 20
) (
    // Clock and reset
    input wire        sys_clk,
    input wire        resetn,
    // Register bus
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Compared data and status
    input wire        rx_valid,
    input wire        rx_err,
    input wire [31:0] rx_pos,
    input wire        running,
    input wire        irq
);
    // Decoded command writes and status clear
    wire cmd_wr   = avs_write && (avs_address[7:2] == 6'h01);
    wire start_wr = cmd_wr && avs_writedata[0] && !avs_writedata[1];
    wire stop_wr  = cmd_wr && avs_writedata[1];
    wire clr_rd   = avs_read && !avs_waitrequest && (avs_address[7:2] == 6'h0d);
    reg  [31:0] run_len;
    reg         stopped;
    // Length of the current run and whether a stop cut it short
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            run_len <= 32'h0;
            stopped <= 1'b0;
        end else if (start_wr && !running) begin
            run_len <= 32'h0;
            stopped <= 1'b0;
        end else if (running) begin
            run_len <= run_len + 32'h1;
            if (stop_wr) begin
                stopped <= 1'b1;
            end
        end
    end
    // Bit-count periods may end well inside one second
    reg         bits_cfg;
    reg         bits_act;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bits_cfg <= 1'b0;
            bits_act <= 1'b0;
        end else begin
            if (avs_write && avs_address[7:2] == 6'h00 && !running
                && avs_writedata[3:2] != 2'h3) begin
                bits_cfg <= (avs_writedata[3:2] == 2'h2);
            end
            if (start_wr && !running) begin
                bits_act <= bits_cfg;
            end
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_rd_wait;
        avs_read && avs_waitrequest;
    endsequence
    sequence s_start;
        start_wr && !running;
    endsequence
    a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
        else $error("write was stalled");
    a_read_answer: assert property (s_rd_wait |=> !avs_waitrequest)
        else $error("read not answered in the next cycle");
    a_idle_nowait: assert property (!avs_read |-> !avs_waitrequest)
        else $error("wait raised without a read");
    a_start_runs: assert property (s_start |=> running)
        else $error("start did not begin a run");
    a_start_cause: assert property ($rose(running) |-> $past(start_wr))
        else $error("run began without a start");
    a_stop_halts: assert property (stop_wr && running |-> ##[1:2] !running)
        else $error("stop did not halt the run");
    a_run_min: assert property ($fell(running) && !stopped && !bits_act |-> run_len >= SEC_CYCLES - 1)
        else $error("period ended before one second");
    a_irq_clear: assert property (clr_rd && !running |=> !irq)
        else $error("interrupt stayed after status read");
endmodule

// *** tb/eag_pat_src.sv ***
`timescale 1ns/1ps
// ========================================
// Far side: one compared bit per cycle while go is high
module eag_pat_src (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        resetn,
    // Bench control
    input  wire        go,
    input  wire        err_on,
    // Compared data
    output reg         rx_valid,
    output reg         rx_err,
    output reg  [31:0] rx_pos
);
    // Positions run 0..15; idle lines toggle so stale values never look valid
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_valid <= 1'b0;
            rx_err   <= 1'b0;
            rx_pos   <= 32'h0;
        end else if (go) begin
            rx_valid <= 1'b1;
            rx_err   <= err_on;
            rx_pos   <= rx_valid ? {28'h0, rx_pos[3:0] + 4'h1} : 32'h0;
        end else begin
            rx_valid <= 1'b0;
            rx_err   <= ~rx_err;
            rx_pos   <= ~rx_pos;
        end
    end
endmodule

// *** tb/error_accumulation_gating_tb.sv ***
`timescale 1ns/1ps
// ========================================
// Self-checking bench for the accumulation gate
module error_accumulation_gating_tb;
    localparam SC = 20;
    reg         sys_clk;
    reg         resetn;
    reg  [7:0]  avs_address;
    reg         avs_read;
    reg         avs_write;
    reg  [31:0] avs_writedata;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire        rx_valid;
    wire        rx_err;
    wire [31:0] rx_pos;
    wire        running;
    wire        irq;
    reg         go;
    reg         err_on;
    reg  [31:0] hi_cnt;
    reg  [31:0] d;
    reg  [31:0] c0;
    integer     err_count;
    integer     samples_checked;
    integer     lows;
    // Clock and running-cycle tally
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (running === 1'b1) hi_cnt <= hi_cnt + 32'h1;
    eag_core #(.SEC_CYCLES(SC)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_err(rx_err),
        .rx_pos(rx_pos), .running(running), .irq(irq));
    eag_pat_src src_u (.sys_clk(sys_clk), .resetn(resetn), .go(go), .err_on(err_on),
        .rx_valid(rx_valid), .rx_err(rx_err), .rx_pos(rx_pos));
    // ========================================
    // Tasks
    task check(input [31:0] seen, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task bus_write(input [5:0] idx, input [31:0] data);
        begin
            @(posedge sys_clk);
            avs_address   <= {idx, 2'b00};
            avs_writedata <= data;
            avs_write     <= 1'b1;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
            avs_write <= 1'b0;
        end
    endtask
    task bus_read(input [5:0] idx, output [31:0] data);
        begin
            @(posedge sys_clk);
            avs_address <= {idx, 2'b00};
            avs_read    <= 1'b1;
            @(posedge sys_clk);
            while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
            data = avs_readdata;
            avs_read <= 1'b0;
        end
    endtask
    task wr_chk(input [5:0] idx, input [31:0] data, input [31:0] exp);
        begin
            bus_write(idx, data);
            bus_read(idx, d);
            check(d, exp);
        end
    endtask
    task burst(input integer n, input e);
        begin
            @(posedge sys_clk);
            go     <= 1'b1;
            err_on <= e;
            repeat (n) @(posedge sys_clk);
            go <= 1'b0;
        end
    endtask
    task wait_idle;
        begin
            @(negedge sys_clk);
            while (running !== 1'b0) @(negedge sys_clk);
        end
    endtask
    task loc_case(input [31:0] ctrl, input [31:0] st, input [31:0] len, input [31:0] exp);
        begin
            bus_write(6'h06, st);
            bus_write(6'h07, len);
            bus_write(6'h00, ctrl);
            bus_write(6'h01, 32'h1);
            burst(16, 1'b1);
            repeat (50) @(negedge sys_clk);
            check({31'h0, running}, 32'h1);
            bus_write(6'h01, 32'h2);
            bus_read(6'h09, d);
            check(d, exp);
            $display("test location %h done", ctrl);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks=%0d mismatches=%0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // Watchdog against a hang
    initial begin
        repeat (6000) @(posedge sys_clk);
        err_count = err_count + 1;
        report_and_stop;
    end
    // ========================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        go = 1'b0;
        err_on = 1'b0;
        hi_cnt = 32'h0;
        err_count = 0;
        samples_checked = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        bus_read(6'h02, d); check(d, 32'h3c);
        bus_read(6'h03, d); check(d, 32'h0a);
        bus_read(6'h07, d); check(d, 32'h1);
        bus_read(6'h3f, d); check(d, 32'h0);
        burst(16, 1'b1);
        bus_read(6'h10, d); check(d, 32'h10);
        bus_read(6'h09, d); check(d, 32'h0);
        $display("test reset and live done");
        wr_chk(6'h03, 32'd50, 32'h0a);
        wr_chk(6'h03, 32'd1000, 32'h3e8);
        wr_chk(6'h03, 32'd100, 32'h64);
        wr_chk(6'h03, 32'd10, 32'h0a);
        wr_chk(6'h02, 32'h0, 32'h3c);
        wr_chk(6'h02, 32'h83d600, 32'h3c);
        wr_chk(6'h02, 32'h83d5ff, 32'h83d5ff);
        wr_chk(6'h02, 32'h2, 32'h2);
        $display("test targets done");
        bus_write(6'h0e, 32'h1);
        bus_write(6'h00, 32'h01);
        c0 = hi_cnt;
        bus_write(6'h01, 32'h1);
        @(negedge sys_clk); check({31'h0, running}, 32'h1);
        check({31'h0, irq}, 32'h0);
        bus_write(6'h00, 32'h02);
        wr_chk(6'h02, 32'h5, 32'h2);
        bus_read(6'h08, d); check(d & 32'hc, 32'h4);
        wait_idle;
        check(hi_cnt - c0, 2 * SC);
        check({31'h0, irq}, 32'h1);
        bus_read(6'h0c, d); check(d, 32'h2);
        bus_read(6'h0d, d); check(d, 32'h5);
        @(negedge sys_clk); check({31'h0, irq}, 32'h0);
        $display("test single time done");
        bus_write(6'h00, 32'h05);
        c0 = hi_cnt;
        bus_write(6'h01, 32'h1);
        // Target of 10 is met mid-second; the period runs on to the first tick
        burst(12, 1'b1);
        wait_idle;
        check(hi_cnt - c0, SC);
        bus_read(6'h08, d); check(d & 32'h2, 32'h2);
        bus_read(6'h09, d); check(d, 32'd12);
        bus_read(6'h0a, d); check(d, 32'd12);
        $display("test error target done");
        // Bit target 5: six bits exceed it, one more lands in the end cycle
        bus_write(6'h04, 32'h5);
        wr_chk(6'h05, 32'hfffc0000, 32'h0);
        bus_write(6'h00, 32'h09);
        bus_write(6'h01, 32'h1);
        burst(12, 1'b0);
        wait_idle;
        bus_read(6'h0a, d); check(d, 32'd7);
        bus_read(6'h0b, d); check(d, 32'h0);
        $display("test bit target done");
        loc_case(32'h00, 32'h4, 32'h3, 32'd16);
        loc_case(32'h10, 32'h4, 32'h3, 32'd3);
        loc_case(32'h20, 32'h5, 32'h3, 32'd1);
        wr_chk(6'h00, 32'h70, 32'h40);
        loc_case(32'h60, 32'h5, 32'h3, 32'd16);
        bus_write(6'h00, 32'h02);
        bus_write(6'h02, 32'h1);
        bus_write(6'h01, 32'h1);
        lows = 0;
        repeat (75) begin
            @(negedge sys_clk);
            if (running !== 1'b1) lows = lows + 1;
        end
        check(lows, 32'h0);
        bus_write(6'h01, 32'h2);
        wait_idle;
        bus_read(6'h0d, d); check(d & 32'h1, 32'h1);
        $display("test repeat done");
        report_and_stop;
    end
endmodule
bind eag_core eag_core_assertions #(.SEC_CYCLES(SEC_CYCLES)) chk_u (.sys_clk(sys_clk),
    .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_err(rx_err),
    .rx_pos(rx_pos), .running(running), .irq(irq));
